// ==== pkg/scl_pkg.sv ====
// Constants, defaults and state type for the switch configuration loader
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package scl_pkg;

	//--------------------------------------------------------------------------
	// Timing
	//--------------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int EE_BIT_NS     = 10000;
	localparam int EE_QTR_CYC    = EE_BIT_NS / (4 * CLK_PERIOD_NS);
	localparam int TICK_W        = 16;

	//--------------------------------------------------------------------------
	// Image layout
	//--------------------------------------------------------------------------
	localparam int         CFG_BYTES        = 54;
	localparam int         NUM_PORTS        = 9;
	localparam int         MASK_W           = 8;
	localparam logic [5:0] REG_GLOBAL_CTRL  = 6'h02;
	localparam logic [5:0] REG_TAG_CLASS    = 6'h03;
	localparam logic [5:0] REG_PORT_CTRL    = 6'h04;
	localparam logic [5:0] REG_PORT_CTRL_LT = 6'h0c;
	localparam logic [5:0] REG_VLAN_MASK    = 6'h0d;
	localparam logic [5:0] REG_TAG_INSERT   = 6'h16;
	localparam logic [5:0] REG_DSCP_MAP     = 6'h28;
	localparam logic [5:0] REG_STATION_ADDR = 6'h30;
	localparam logic [5:0] REG_LAST         = 6'h35;

	// Global control fields
	localparam int GC_VLAN_ENF  = 0;
	localparam int GC_BUF_RSV   = 1;
	localparam int GC_SCHEME_LO = 2;
	localparam int GC_SCHEME_HI = 3;
	// Port control fields
	localparam int PC_QSPLIT   = 0;
	localparam int PC_STRIP    = 1;
	localparam int PC_INSERT   = 2;
	localparam int PC_PORTPRIO = 3;
	localparam int PC_TAGPRIO  = 4;
	localparam int PC_DSCP     = 5;

	localparam logic [12:0] HIGH_RESERVE_BYTES = 13'h1800;

	//--------------------------------------------------------------------------
	// Serial memory addressing
	//--------------------------------------------------------------------------
	localparam logic [3:0] EE_CTRL_CODE  = 4'ha;
	localparam logic [2:0] EE_CHIP_SEL   = 3'h0;
	localparam logic [7:0] EE_DEV_WR     = {EE_CTRL_CODE, EE_CHIP_SEL, 1'b0};
	localparam logic [7:0] EE_DEV_RD     = {EE_CTRL_CODE, EE_CHIP_SEL, 1'b1};
	localparam logic [7:0] EE_START_ADDR = 8'h00;
	localparam logic [3:0] EE_ACK_BIT    = 4'h8;
	localparam logic [1:0] PH_FIRST      = 2'h0;
	localparam logic [1:0] PH_RISE       = 2'h1;
	localparam logic [1:0] PH_SAMPLE     = 2'h2;
	localparam logic [1:0] PH_LAST       = 2'h3;

	// Slave shifter: first bit of byte 0 has no clock
	localparam logic [2:0] SLV_FIRST_BIT = 3'h1;
	localparam logic [2:0] SLV_LAST_BIT  = 3'h7;

	//--------------------------------------------------------------------------
	// Defaults held until a valid load
	//--------------------------------------------------------------------------
	localparam logic [7:0] DEF_TAG_CLASS = 8'he0;
	localparam logic [7:0] DEF_VLAN_MASK = 8'hff;
	localparam logic [7:0] DEF_ZERO      = 8'h00;

	function automatic logic [7:0] scl_default(input logic [5:0] idx);
		if (idx == REG_TAG_CLASS)
			return DEF_TAG_CLASS;
		else if (idx >= REG_VLAN_MASK && idx < REG_TAG_INSERT)
			return DEF_VLAN_MASK;
		else
			return DEF_ZERO;
	endfunction

	typedef enum logic [3:0] {
		ST_WAIT,
		ST_START,
		ST_DEVW,
		ST_ADDR,
		ST_RESTART,
		ST_DEVR,
		ST_READ,
		ST_STOP,
		ST_SLAVE,
		ST_DONE
	} scl_state_e;

endpackage

// ==== logic/scl_config_loader.sv ====
// Configuration loader: serial memory master, processor slave, image and lookups
module scl_config_loader
	import scl_pkg::*;
#(
	parameter logic [7:0] SIG_BYTE0 = 8'h3c,     // Arbitrary signature value
	parameter logic [7:0] SIG_BYTE1 = 8'hc3,     // Arbitrary signature value
	parameter int         QTR_CYC   = EE_QTR_CYC
)(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        SCL_LINK_CLK,
	input  wire logic        CONFIG_SOURCE_SELECT,
	input  wire logic        TAG_PRIO_STRAP,
	input  wire logic        SDA_I,
	output logic             SCL_O,
	output logic             SCL_OE,
	output logic             SDA_O,
	output logic             SDA_OE,
	input  wire logic [3:0]  Q_PORT,
	input  wire logic [2:0]  Q_TAG_PRIO,
	input  wire logic        Q_TAGGED,
	input  wire logic [5:0]  Q_DSCP,
	input  wire logic        Q_IS_IPV4,
	input  wire logic        Q_UNICAST,
	output logic             R_HIGH_PRIO,
	output logic [7:0]       R_FWD_MASK,
	output logic             R_QUEUE_SPLIT,
	output logic             R_INSERT_TAG,
	output logic             R_STRIP_TAG,
	output logic [15:0]      R_TAG_VALUE,
	output logic [1:0]       PRIO_SCHEME,
	output logic [12:0]      HIGH_RESERVE_SIZE,
	output logic             UNICAST_VLAN_ENFORCE,
	output logic [47:0]      STATION_ADDR,
	output logic             CONFIG_DONE,
	output logic             SIGNATURE_FAIL
);

	//--------------------------------------------------------------------------
	// Link domain: processor-clocked shifter
	//--------------------------------------------------------------------------
	logic [2:0] lk_bit_q;
	logic [6:0] lk_shift_q;
	logic [7:0] lk_byte_q;
	logic       lk_tgl_q;

	// Shift MSB first on rising link clock, skipping the unclocked first bit
	always_ff @(posedge SCL_LINK_CLK or posedge RST)
	begin
		if (RST)
		begin
			lk_bit_q   <= SLV_FIRST_BIT;
			lk_shift_q <= '0;
			lk_byte_q  <= '0;
			lk_tgl_q   <= 1'b0;
		end
		else
		begin
			lk_shift_q <= {lk_shift_q[5:0], SDA_I};
			lk_bit_q   <= lk_bit_q + 3'h1;
			if (lk_bit_q == SLV_LAST_BIT)
			begin
				lk_byte_q <= {lk_shift_q, SDA_I};
				lk_tgl_q  <= ~lk_tgl_q;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Synchronisers into the system clock
	//--------------------------------------------------------------------------
	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic sda_s1_q, sda_s2_q;
	logic mode_s1_q, mode_s2_q;
	logic tagp_s1_q, tagp_s2_q;

	// Two flops per input, third flop only for the toggle edge
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			{tgl_s1_q, tgl_s2_q, tgl_s3_q} <= 3'h0;
			{sda_s1_q, sda_s2_q}           <= 2'h3;
			{mode_s1_q, mode_s2_q}         <= 2'h0;
			{tagp_s1_q, tagp_s2_q}         <= 2'h0;
		end
		else
		begin
			tgl_s1_q  <= lk_tgl_q;
			tgl_s2_q  <= tgl_s1_q;
			tgl_s3_q  <= tgl_s2_q;
			sda_s1_q  <= SDA_I;
			sda_s2_q  <= sda_s1_q;
			mode_s1_q <= CONFIG_SOURCE_SELECT;
			mode_s2_q <= mode_s1_q;
			tagp_s1_q <= TAG_PRIO_STRAP;
			tagp_s2_q <= tagp_s1_q;
		end
	end

	// Byte from the processor is stable for a full byte time after the toggle
	wire slv_byte_stb = tgl_s2_q ^ tgl_s3_q;

	//--------------------------------------------------------------------------
	// Quarter-bit timer for the memory master
	//--------------------------------------------------------------------------
	logic [TICK_W-1:0] tick_cnt_q;
	wire               tick = (tick_cnt_q == TICK_W'(QTR_CYC - 1));

	// Free-running divider
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
	end

	//--------------------------------------------------------------------------
	// Sequencer state
	//--------------------------------------------------------------------------
	scl_state_e state_q;
	logic [1:0] phase_q;
	logic [3:0] bitn_q;
	logic [7:0] txsh_q;
	logic [7:0] rxsh_q;
	logic [5:0] idx_q;
	logic       done_q;
	logic       sigfail_q;
	logic       ctrl_loaded_q;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic       out_low_q;

	// Bit framing events
	wire bit_end    = tick && (phase_q == PH_LAST);
	wire sample_now = tick && (phase_q == PH_SAMPLE);
	wire tx_state   = (state_q == ST_DEVW) || (state_q == ST_ADDR) || (state_q == ST_DEVR);
	wire at_ack     = (bitn_q == EE_ACK_BIT);

	// Signature check on the first two bytes read
	wire sig_bad = ((idx_q == 6'h00) && (rxsh_q != SIG_BYTE0))
		|| ((idx_q == 6'h01) && (rxsh_q != SIG_BYTE1));
	wire last_rd = (idx_q == REG_LAST);
	wire rd_nack = last_rd || sig_bad;

	//--------------------------------------------------------------------------
	// Pin levels per state and phase
	//--------------------------------------------------------------------------
	logic scl_low_d;
	logic sda_low_d;

	// Data bits move only in phase 0 while the clock is already low; start, restart and stop edges move data with the clock high
	always_comb
	begin
		scl_low_d = 1'b0;
		sda_low_d = 1'b0;
		case (state_q)
			ST_START:
			begin
				sda_low_d = (phase_q != PH_FIRST);
				scl_low_d = (phase_q == PH_SAMPLE) || (phase_q == PH_LAST);
			end
			ST_DEVW, ST_ADDR, ST_DEVR:
			begin
				scl_low_d = (phase_q == PH_FIRST) || (phase_q == PH_LAST);
				sda_low_d = !at_ack && !txsh_q[7];
			end
			ST_READ:
			begin
				scl_low_d = (phase_q == PH_FIRST) || (phase_q == PH_LAST);
				sda_low_d = at_ack && !rd_nack;
			end
			ST_RESTART:
			begin
				scl_low_d = (phase_q == PH_FIRST) || (phase_q == PH_LAST);
				sda_low_d = (phase_q == PH_SAMPLE) || (phase_q == PH_LAST);
			end
			ST_STOP:
			begin
				scl_low_d = (phase_q == PH_FIRST);
				sda_low_d = (phase_q == PH_FIRST) || (phase_q == PH_RISE);
			end
			default:
			begin
				scl_low_d = 1'b0;
				sda_low_d = 1'b0;
			end
		endcase
	end

	// Open-drain drivers from flops
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
			out_low_q <= 1'b0;
		end
		else
		begin
			scl_oe_q  <= scl_low_d;
			sda_oe_q  <= sda_low_d;
			out_low_q <= 1'b0;
		end
	end

	//--------------------------------------------------------------------------
	// Image write port
	//--------------------------------------------------------------------------
	wire       rd_store = (state_q == ST_READ) && bit_end && at_ack && (idx_q >= REG_GLOBAL_CTRL);
	wire       slv_wr   = (state_q == ST_SLAVE) && slv_byte_stb;
	wire       img_we   = rd_store || slv_wr;
	wire [7:0] img_wd   = slv_wr ? lk_byte_q : rxsh_q;

	//--------------------------------------------------------------------------
	// Load sequencer
	//--------------------------------------------------------------------------
	// Master: start, device write, address 0, restart, device read, up to 54 reads, stop
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			state_q       <= ST_WAIT;
			phase_q       <= PH_FIRST;
			bitn_q        <= '0;
			txsh_q        <= '0;
			rxsh_q        <= '0;
			idx_q         <= '0;
			done_q        <= 1'b0;
			sigfail_q     <= 1'b0;
			ctrl_loaded_q <= 1'b0;
		end
		else
		begin
			if (tick)
				phase_q <= phase_q + 2'h1;
			if (img_we && (idx_q == REG_PORT_CTRL_LT))
				ctrl_loaded_q <= 1'b1;
			case (state_q)
				ST_WAIT:
				begin
					phase_q <= PH_FIRST;
					if (tick)
						state_q <= mode_s2_q ? ST_START : ST_SLAVE;
				end
				ST_START:
				begin
					if (bit_end)
					begin
						state_q <= ST_DEVW;
						txsh_q  <= EE_DEV_WR;
						bitn_q  <= '0;
					end
				end
				ST_DEVW, ST_ADDR, ST_DEVR:
				begin
					if (bit_end && !at_ack)
					begin
						txsh_q <= {txsh_q[6:0], 1'b0};
						bitn_q <= bitn_q + 4'h1;
					end
					else if (bit_end)
					begin
						bitn_q <= '0;
						if (state_q == ST_DEVW)
						begin
							state_q <= ST_ADDR;
							txsh_q  <= EE_START_ADDR;
						end
						else if (state_q == ST_ADDR)
							state_q <= ST_RESTART;
						else
							state_q <= ST_READ;
					end
				end
				ST_RESTART:
				begin
					if (bit_end)
					begin
						state_q <= ST_DEVR;
						txsh_q  <= EE_DEV_RD;
						bitn_q  <= '0;
					end
				end
				ST_READ:
				begin
					if (sample_now && !at_ack)
						rxsh_q <= {rxsh_q[6:0], sda_s2_q};
					if (bit_end && !at_ack)
						bitn_q <= bitn_q + 4'h1;
					else if (bit_end)
					begin
						bitn_q <= '0;
						if (rd_nack)
						begin
							state_q   <= ST_STOP;
							sigfail_q <= sig_bad;
						end
						else
							idx_q <= idx_q + 6'h1;
					end
				end
				ST_STOP:
				begin
					if (bit_end)
					begin
						state_q <= ST_DONE;
						done_q  <= 1'b1;
					end
				end
				ST_SLAVE:
				begin
					if (slv_byte_stb && (idx_q == REG_LAST))
					begin
						state_q <= ST_DONE;
						done_q  <= 1'b1;
					end
					else if (slv_byte_stb)
						idx_q <= idx_q + 6'h1;
				end
				ST_DONE:
					done_q <= 1'b1;
				default:
					state_q <= ST_WAIT;
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// Configuration image
	//--------------------------------------------------------------------------
	logic [7:0] img_q [CFG_BYTES];

	// Each byte resets to its default; memory loads write bytes 2 and up, processor loads write every byte
	for (genvar g = 0; g < CFG_BYTES; g++)
	begin : g_img
		always_ff @(posedge CLOCK or posedge RST)
		begin
			if (RST)
				img_q[g] <= scl_default(6'(g));
			else if (img_we && (idx_q == 6'(g)))
				img_q[g] <= img_wd;
		end
	end

	//--------------------------------------------------------------------------
	// Per-frame lookup
	//--------------------------------------------------------------------------
	wire [5:0] q_port6   = {2'h0, Q_PORT};
	wire       port_ok   = (Q_PORT < 4'(NUM_PORTS)) && done_q;
	wire [7:0] q_ctrl    = img_q[REG_PORT_CTRL + q_port6];
	wire [7:0] q_mask    = img_q[REG_VLAN_MASK + q_port6];
	wire [5:0] q_tag_idx = REG_TAG_INSERT + {q_port6[4:0], 1'b0};
	wire [7:0] q_dmap    = img_q[REG_DSCP_MAP + {3'h0, Q_DSCP[5:3]}];
	wire       dscp_bit  = q_dmap[Q_DSCP[2:0]];
	wire       class_bit = img_q[REG_TAG_CLASS][Q_TAG_PRIO];
	wire [7:0] gctrl     = img_q[REG_GLOBAL_CTRL];

	// Strap enables tag priority unless a loaded control byte says otherwise
	wire tag_en  = ctrl_loaded_q ? q_ctrl[PC_TAGPRIO]
		: (q_ctrl[PC_TAGPRIO] || tagp_s2_q);
	wire dscp_hi = q_ctrl[PC_DSCP] && Q_IS_IPV4 && dscp_bit;
	wire tag_hi  = tag_en && Q_TAGGED && class_bit;
	wire prio_hi = port_ok && (dscp_hi || tag_hi || q_ctrl[PC_PORTPRIO]);

	// Unicast may ignore the mask; group frames never do
	wire       uni_free = Q_UNICAST && !gctrl[GC_VLAN_ENF];
	wire [7:0] fwd_d    = !port_ok ? '0 : (uni_free ? {MASK_W{1'b1}} : q_mask);

	// Registered lookup answers
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			R_HIGH_PRIO   <= 1'b0;
			R_FWD_MASK    <= '0;
			R_QUEUE_SPLIT <= 1'b0;
			R_INSERT_TAG  <= 1'b0;
			R_STRIP_TAG   <= 1'b0;
			R_TAG_VALUE   <= '0;
		end
		else
		begin
			R_HIGH_PRIO   <= prio_hi;
			R_FWD_MASK    <= fwd_d;
			R_QUEUE_SPLIT <= port_ok && q_ctrl[PC_QSPLIT];
			R_INSERT_TAG  <= port_ok && q_ctrl[PC_INSERT] && !Q_TAGGED;
			R_STRIP_TAG   <= port_ok && q_ctrl[PC_STRIP] && Q_TAGGED;
			R_TAG_VALUE   <= {img_q[q_tag_idx], img_q[q_tag_idx + 6'h1]};
		end
	end

	//--------------------------------------------------------------------------
	// Global settings and status
	//--------------------------------------------------------------------------
	logic [12:0] reserve_q;

	// Reserved high priority buffer size
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			reserve_q <= '0;
		else
			reserve_q <= gctrl[GC_BUF_RSV] ? HIGH_RESERVE_BYTES : '0;
	end

	// Station address, byte 48 most significant
	for (genvar k = 0; k < 6; k++)
	begin : g_sa
		assign STATION_ADDR[47 - 8 * k -: 8] = img_q[REG_STATION_ADDR + 6'(k)];
	end

	assign PRIO_SCHEME          = gctrl[GC_SCHEME_HI:GC_SCHEME_LO];
	assign HIGH_RESERVE_SIZE    = reserve_q;
	assign UNICAST_VLAN_ENFORCE = gctrl[GC_VLAN_ENF];
	assign CONFIG_DONE          = done_q;
	assign SIGNATURE_FAIL       = sigfail_q;
	assign SCL_O                = out_low_q;
	assign SDA_O                = out_low_q;
	assign SCL_OE               = scl_oe_q;
	assign SDA_OE               = sda_oe_q;

endmodule

// ==== sim/scl_props.sv ====
// Concurrent checks on the configuration loader top-level ports
module scl_props (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic        SCL_OE,
	input wire logic        SDA_OE,
	input wire logic [3:0]  Q_PORT,
	input wire logic        Q_TAGGED,
	input wire logic [7:0]  R_FWD_MASK,
	input wire logic        R_INSERT_TAG,
	input wire logic        R_STRIP_TAG,
	input wire logic [1:0]  PRIO_SCHEME,
	input wire logic [12:0] HIGH_RESERVE_SIZE,
	input wire logic [47:0] STATION_ADDR,
	input wire logic        CONFIG_DONE,
	input wire logic        SIGNATURE_FAIL
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	// Data edges while the clock line is released
	sequence s_start;
		$rose(SDA_OE) && !SCL_OE;
	endsequence
	sequence s_stop;
		$fell(SDA_OE) && !SCL_OE;
	endsequence

	property p_start_clk;
		s_start |-> ##[1:8] $rose(SCL_OE);
	endproperty
	a_start_clk: assert property (p_start_clk) else $error("start without clock low");
	property p_stop_done;
		s_stop |-> ##[1:16] CONFIG_DONE;
	endproperty
	a_stop_done: assert property (p_stop_done) else $error("stop without done");
	property p_done_hold;
		CONFIG_DONE |=> CONFIG_DONE;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done dropped");
	property p_done_quiet;
		CONFIG_DONE |-> !SCL_OE && !SDA_OE;
	endproperty
	a_done_quiet: assert property (p_done_quiet) else $error("bus driven after done");
	property p_hold_fwd;
		!CONFIG_DONE ##1 1'b1 |-> R_FWD_MASK == 8'h00;
	endproperty
	a_hold_fwd: assert property (p_hold_fwd) else $error("forwarding before load");
	property p_port_range;
		Q_PORT >= 4'h9 |=> R_FWD_MASK == 8'h00;
	endproperty
	a_port_range: assert property (p_port_range) else $error("mask for absent port");
	property p_reserve;
		HIGH_RESERVE_SIZE == 13'h0 || HIGH_RESERVE_SIZE == 13'h1800;
	endproperty
	a_reserve: assert property (p_reserve) else $error("bad reserve size");
	property p_insert;
		Q_TAGGED |=> !R_INSERT_TAG;
	endproperty
	a_insert: assert property (p_insert) else $error("insert on tagged frame");
	property p_strip;
		!Q_TAGGED |=> !R_STRIP_TAG;
	endproperty
	a_strip: assert property (p_strip) else $error("strip on untagged frame");
	property p_fail_def;
		SIGNATURE_FAIL && CONFIG_DONE |-> STATION_ADDR == 48'h0 && PRIO_SCHEME == 2'h0;
	endproperty
	a_fail_def: assert property (p_fail_def) else $error("image changed on bad signature");
endmodule

bind scl_config_loader scl_props u_props (.CLOCK, .RST, .SCL_OE, .SDA_OE, .Q_PORT, .Q_TAGGED, .R_FWD_MASK,
	.R_INSERT_TAG, .R_STRIP_TAG, .PRIO_SCHEME, .HIGH_RESERVE_SIZE, .STATION_ADDR, .CONFIG_DONE, .SIGNATURE_FAIL);

// ==== sim/scl_eeprom_model.sv ====
// Behavioural serial memory answering sequential reads from address zero
module scl_eeprom_model (
	input  wire logic  en,
	input  wire logic  scl,
	input  wire logic  sda,
	output logic       sda_oe,
	output logic [7:0] dev_byte
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] mem [54];
	int         nstart = 0;
	int         cnt = 0;
	int         m;

	initial sda_oe = 1'b0;
	initial dev_byte = 8'h00;

	// Start and stop are data edges while the clock is high
	always @(negedge sda)
		if (en && scl)
		begin
			nstart = nstart + 1;
			cnt = 0;
		end
	always @(posedge sda)
		if (en && scl)
			nstart = 0;

	// Select byte capture, and end of reading on a master NACK
	always @(posedge scl)
	begin
		if (en && nstart == 1 && cnt >= 1 && cnt <= 8)
			dev_byte = {dev_byte[6:0], sda};
		if (nstart == 2 && cnt >= 10 && (cnt - 10) % 9 == 8 && sda)
			nstart = 0;
	end

	// Read data changes only while the clock is low
	always @(negedge scl)
	begin
		cnt = cnt + 1;
		m = cnt - 10;
		sda_oe <= en && nstart == 2 && m >= 0 && m % 9 < 8 && m / 9 < 54 && !mem[m / 9][7 - m % 9];
	end
endmodule

// ==== sim/test_switch_config_loader.sv ====
// Self-checking bench for the switch configuration loader
module test_switch_config_loader
	import scl_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	localparam int         QTR  = 3;
	localparam logic [7:0] SIG0 = 8'h5a; // Arbitrary signature value
	localparam logic [7:0] SIG1 = 8'ha6; // Arbitrary signature value

	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        src = 1'b1;
	logic        strap = 1'b1;
	logic        tagd = 1'b0;
	logic        ip4 = 1'b0;
	logic        uni = 1'b0;
	logic [3:0]  port = 4'h0;
	logic [2:0]  prio = 3'h0;
	logic [5:0]  dscp = 6'h00;
	logic        pscl = 1'b1;
	logic        psda = 1'b1;
	wire         scl_oe, sda_oe, mem_oe, hi, ins, stp, qs, done, sfail, uve;
	wire  [7:0]  fwd, dev;
	wire  [15:0] tagv;
	wire  [1:0]  sch;
	wire  [12:0] rsv;
	wire  [47:0] sta;
	wire         scl_w = !scl_oe && pscl;
	wire         sda_w = !sda_oe && !mem_oe && psda;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	scl_config_loader #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .QTR_CYC(QTR)) u_dut (
		.CLOCK(clock), .RST(rst), .SCL_LINK_CLK(scl_w), .CONFIG_SOURCE_SELECT(src), .TAG_PRIO_STRAP(strap),
		.SDA_I(sda_w), .SCL_O(), .SCL_OE(scl_oe), .SDA_O(), .SDA_OE(sda_oe), .Q_PORT(port), .Q_TAG_PRIO(prio),
		.Q_TAGGED(tagd), .Q_DSCP(dscp), .Q_IS_IPV4(ip4), .Q_UNICAST(uni), .R_HIGH_PRIO(hi), .R_FWD_MASK(fwd),
		.R_QUEUE_SPLIT(qs), .R_INSERT_TAG(ins), .R_STRIP_TAG(stp), .R_TAG_VALUE(tagv), .PRIO_SCHEME(sch),
		.HIGH_RESERVE_SIZE(rsv), .UNICAST_VLAN_ENFORCE(uve), .STATION_ADDR(sta), .CONFIG_DONE(done),
		.SIGNATURE_FAIL(sfail));
	scl_eeprom_model u_mem (.en(src), .scl(scl_w), .sda(sda_w), .sda_oe(mem_oe), .dev_byte(dev));

	// Clock and hang limit
	always #2 clock = !clock;
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(string name, logic [47:0] seen, logic [47:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Image contents for all scenarios; alt selects the byte 2 global control value
	function automatic logic [7:0] img(int k, bit alt);
		case (k)
			0: return SIG0;
			1: return SIG1;
			2: return alt ? 8'h04 : 8'h0b;
			3: return 8'h81;
			4: return 8'h10;
			5: return 8'h20;
			6: return 8'h08;
			7: return 8'h07;
			default: return (k < 13) ? 8'h00 : 8'(k) ^ 8'ha5;
		endcase
	endfunction

	task automatic do_reset(logic s);
		src <= s;
		rst <= 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
	endtask

	task automatic wait_done();
		for (int i = 0; i < 20000 && done !== 1'b1; i++)
			@(posedge clock);
		#1;
	endtask

	// One lookup, answer read one cycle later
	task automatic q(logic [3:0] p, logic [2:0] pr, logic tg, logic [5:0] d, logic v4, logic u);
		@(posedge clock);
		port <= p;
		prio <= pr;
		tagd <= tg;
		dscp <= d;
		ip4 <= v4;
		uni <= u;
		@(posedge clock);
		#1;
	endtask

	task automatic run_master(bit bad);
		logic [7:0]  b;
		logic [47:0] a;
		for (int k = 0; k < 54; k++)
			u_mem.mem[k] = img(k, 1'b0);
		if (bad)
			u_mem.mem[1] = ~SIG1;
		do_reset(1'b1);
		wait_done();
		chk("done", done, 1'b1);
		chk("sig_fail", sfail, bad);
		chk("dev_addr", dev, EE_DEV_WR);
		for (int k = 0; k < 6; k++)
			a[47 - 8 * k -: 8] = bad ? 8'h00 : img(48 + k, 1'b0);
		chk("station", sta, a);
		chk("scheme", sch, bad ? 2'h0 : 2'h2);
		chk("reserve", rsv, bad ? 13'h0 : 13'h1800);
		chk("uc_enforce", uve, !bad);
		q(4'h0, 3'h0, 1'b1, 6'h00, 1'b0, 1'b1);
		chk("tag0", hi, !bad);
		q(4'h0, 3'h5, 1'b1, 6'h00, 1'b0, 1'b1);
		chk("tag5", hi, bad);
		q(4'h0, 3'h4, 1'b1, 6'h00, 1'b0, 1'b1);
		chk("tag4", hi, 1'b0);
		if (bad)
		begin
			chk("def_mask", fwd, 8'hff);
			return;
		end
		q(4'h1, 3'h7, 1'b1, 6'h00, 1'b0, 1'b1);
		chk("tag_off", hi, 1'b0);
		q(4'h2, 3'h0, 1'b0, 6'h00, 1'b0, 1'b1);
		chk("port_prio", hi, 1'b1);
		for (int k = 0; k < 64; k++)
		begin
			b = img(40 + k / 8, 1'b0);
			q(4'h1, 3'h0, 1'b0, 6'(k), 1'b1, 1'b1);
			chk("dscp", hi, b[k % 8]);
		end
		q(4'h3, 3'h0, 1'b0, 6'h00, 1'b0, 1'b1);
		chk("split", qs, 1'b1);
		chk("insert", ins, 1'b1);
		q(4'h3, 3'h0, 1'b1, 6'h00, 1'b0, 1'b1);
		chk("strip", stp, 1'b1);
		for (int p = 0; p < 10; p++)
		begin
			q(4'(p), 3'h0, 1'b0, 6'h00, 1'b0, p[0]);
			chk("mask", fwd, p < 9 ? img(13 + p, 1'b0) : 8'h00);
			if (p < 9)
				chk("tag_val", tagv, {img(22 + 2 * p, 1'b0), img(23 + 2 * p, 1'b0)});
		end
	endtask

	// Processor clocks 431 bits in, MSB first, byte 0 bit 7 unclocked
	task automatic run_slave();
		logic [7:0]  b;
		logic [47:0] a;
		do_reset(1'b0);
		repeat (QTR + 4) @(posedge clock);
		#7;
		for (int k = 1; k < 432; k++)
		begin
			b = img(k / 8, 1'b1);
			pscl = 1'b0;
			#20 psda = b[7 - k % 8];
			#20 pscl = 1'b1;
			#40;
			if (k == 430)
				chk("early_done", done, 1'b0);
		end
		psda = 1'b1;
		wait_done();
		chk("slv_done", done, 1'b1);
		chk("slv_fail", sfail, 1'b0);
		for (int k = 0; k < 6; k++)
			a[47 - 8 * k -: 8] = img(48 + k, 1'b1);
		chk("slv_station", sta, a);
		chk("slv_scheme", sch, 2'h1);
		chk("slv_reserve", rsv, 13'h0);
		q(4'h0, 3'h0, 1'b0, 6'h00, 1'b0, 1'b1);
		chk("uc_free", fwd, 8'hff);
		q(4'h0, 3'h0, 1'b0, 6'h00, 1'b0, 1'b0);
		chk("mc_mask", fwd, img(13, 1'b1));
	endtask

	initial
	begin
		run_master(1'b0);
		run_master(1'b1);
		run_slave();
		report_and_stop();
	end
endmodule
